// file: amc_mode_ctrl.sv
// Output mode control for a dual-channel converter with four parallel DDR buses
//
// Local design decisions: the plain strobed port and the register addresses.
`include "amc_regs.svh"

module amc_mode_ctrl (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Sampling clock pin and converter words
	input wire logic sample_clk_i,
	input wire logic [11:0] conv_a_i,
	input wire logic [11:0] conv_b_i,
	// Analog and driver controls
	output logic interleave_o,
	output logic chan_a_src_o,
	output logic chan_b_src_o,
	output logic trim_sel_o,
	output logic dither_on_o,
	output logic dither_boost_o,
	output logic dither_rounding_choice_o,
	output logic swing_low_o,
	output logic swing_highz_o,
	// Output buses A to D
	output amc_pkg::amc_lane_type [3:0] bus_o
);

	amc_pkg::amc_mode_type m;
	amc_pkg::amc_dither_type dith;
	logic [1:0] swing;
	logic [7:0] clock_strobe_enable_reg;
	logic [1:0] sync_pattern_select;
	logic clk_meta, clk_sync, clk_last;
	logic rise, fall, evt, last;
	logic [1:0] ph, ph_last;
	logic [11:0] word_now;
	logic [3:0] wm, upd, act, stb_act, dclk_act;
	logic [11:0] wv [4];
	logic [11:0] pend [4];
	logic [11:0] data_q [4];
	logic [2:0] fc [4];
	logic [3:0] stb_q, dclk_q;
	logic [2:0] n_bus, n_stb, n_dclk;
	logic [5:0] n_pairs;
	logic [15:0] rate_min, rate_max;
	logic [31:0] next_rdata;

	// Register writes; reads have no side effects
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			m <= `AMC_MODE_RST;
			dith <= `AMC_DITH_RST;
			swing <= `AMC_SWING_RST;
			clock_strobe_enable_reg <= `AMC_CSE_RST;
			sync_pattern_select <= `AMC_SYNC_RST;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == `AMC_ADDR_MODE)
				m <= reg_wdata_i[5:0];
			else if (reg_addr_i == `AMC_ADDR_DITHER)
				dith <= reg_wdata_i[2:0];
			else if (reg_addr_i == `AMC_ADDR_SWING)
				swing <= reg_wdata_i[1:0];
			else if (reg_addr_i == `AMC_ADDR_CSE)
				clock_strobe_enable_reg <= reg_wdata_i[7:0];
			else if (reg_addr_i == `AMC_ADDR_SYNC)
				sync_pattern_select <= reg_wdata_i[1:0];
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb
	begin
		next_rdata = 32'h0;
		if (reg_addr_i == `AMC_ADDR_MODE)
			next_rdata = {26'h0, m};
		else if (reg_addr_i == `AMC_ADDR_DITHER)
			next_rdata = {29'h0, dith};
		else if (reg_addr_i == `AMC_ADDR_SWING)
			next_rdata = {30'h0, swing};
		else if (reg_addr_i == `AMC_ADDR_CSE)
			next_rdata = {24'h0, clock_strobe_enable_reg};
		else if (reg_addr_i == `AMC_ADDR_SYNC)
			next_rdata = {30'h0, sync_pattern_select};
		else if (reg_addr_i == `AMC_ADDR_STATUS)
			next_rdata = {10'h0, n_pairs, 5'h0, n_dclk, 1'b0, n_stb, 1'b0, n_bus};
		else if (reg_addr_i == `AMC_ADDR_RATE)
			next_rdata = {rate_max, rate_min};
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			reg_rdata_o <= 32'h0;
		else if (reg_rd_i)
			reg_rdata_o <= next_rdata;
		else
			reg_rdata_o <= 32'h0;
	end

	// Geometry of the chosen mode
	always_comb
	begin
		n_bus = m.demux ? 3'h4 : 3'h2;
		n_pairs = m.demux ? `AMC_PAIRS_FOUR : `AMC_PAIRS_TWO;
		n_stb = 3'($countones(stb_act));
		n_dclk = 3'($countones(dclk_act));
		if (m.intlv)
		begin
			rate_min = `AMC_RATE_INTLV_MIN;
			rate_max = m.demux ? `AMC_RATE_INTLV4_MAX : `AMC_RATE_INTLV2_MAX;
		end
		else
		begin
			rate_min = `AMC_RATE_DUAL_MIN;
			rate_max = m.demux ? `AMC_RATE_DUAL4_MAX : `AMC_RATE_DUAL2_MAX;
		end
	end

	// Analog side controls; swap only matters with two channels
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			interleave_o <= 1'b0;
			chan_a_src_o <= 1'b0;
			chan_b_src_o <= 1'b1;
			trim_sel_o <= 1'b0;
		end
		else
		begin
			interleave_o <= m.intlv;
			chan_a_src_o <= m.intlv ? m.isel : m.swap;
			chan_b_src_o <= m.intlv ? m.isel : ~m.swap;
			trim_sel_o <= m.intlv & m.isel;
		end
	end

	// Dither and driver settings
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			dither_on_o <= 1'b1;
			dither_boost_o <= 1'b0;
			dither_rounding_choice_o <= 1'b0;
			swing_low_o <= 1'b0;
			swing_highz_o <= 1'b0;
		end
		else
		begin
			dither_on_o <= dith.on;
			dither_boost_o <= dith.boost;
			dither_rounding_choice_o <= dith.round;
			swing_low_o <= swing == `AMC_SWING_LOW;
			swing_highz_o <= swing == `AMC_SWING_HIZ;
		end
	end

	// Two-stage synchroniser on the sampling clock, then edge history
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			clk_meta <= 1'b0;
			clk_sync <= 1'b0;
			clk_last <= 1'b0;
		end
		else
		begin
			clk_meta <= sample_clk_i;
			clk_sync <= clk_meta;
			clk_last <= clk_sync;
		end
	end

	// Sampling instants: rising only, or both edges when interleaved
	assign rise = clk_sync & ~clk_last;
	assign fall = ~clk_sync & clk_last;
	assign evt = m.lvds_en & (rise | (m.intlv & fall));
	assign word_now = rise ? conv_a_i : conv_b_i;
	assign ph_last = m.intlv ? (m.demux ? 2'h3 : 2'h1) : (m.demux ? 2'h1 : 2'h0);
	assign last = ph == ph_last;

	// Position within a group of sampling instants
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || !m.lvds_en)
			ph <= 2'h0;
		else if (evt)
			ph <= last ? 2'h0 : ph + 2'h1;
	end

	// Which bus takes the current sample
	always_comb
	begin
		wm = 4'h0;
		if (m.intlv)
			wm[m.demux ? ph : {1'b0, ph[0]}] = evt;
		else if (m.demux && ph[0])
			wm = {evt, evt, 2'b00};
		else
			wm = {2'b00, evt, evt};
	end

	// Per-bus data path, framing and output stage
	genvar b;
	generate
		for (b = 0; b < 4; b++)
		begin : g_bus
			// Even buses carry channel A words in two-channel mode
			assign wv[b] = m.intlv ? word_now : ((b % 2 == 1) ? conv_b_i : conv_a_i);
			assign act[b] = m.lvds_en & (b < 2 || m.demux);
			assign upd[b] = act[b] & (m.align ? (evt & last) : wm[b]);
			assign stb_act[b] = act[b] & (!m.demux || clock_strobe_enable_reg[b])
				& (sync_pattern_select != `AMC_SYNC_LSB);
			assign dclk_act[b] = act[b] & (!m.demux || clock_strobe_enable_reg[4 + b]);

			// Aligned mode parks words until the group is complete
			always_ff @(posedge core_clk_i)
			begin
				if (rst_i)
					pend[b] <= 12'h0;
				else if (wm[b])
					pend[b] <= wv[b];
			end

			// Word, frame count, strobe and clock move on the same edge
			always_ff @(posedge core_clk_i)
			begin
				if (rst_i || !m.lvds_en)
				begin
					data_q[b] <= 12'h0;
					fc[b] <= 3'h0;
					stb_q[b] <= 1'b0;
					dclk_q[b] <= 1'b0;
				end
				else if (upd[b])
				begin
					data_q[b] <= wm[b] ? wv[b] : pend[b];
					fc[b] <= fc[b] + 3'h1;
					stb_q[b] <= fc[b] == `AMC_FRAME_LAST;
					dclk_q[b] <= ~dclk_q[b];
				end
			end

			// Gating in a final register keeps every pin glitch free
			always_ff @(posedge core_clk_i)
			begin
				if (rst_i)
					bus_o[b] <= '0;
				else
				begin
					bus_o[b].data[11:1] <= act[b] ? data_q[b][11:1] : 11'h0;
					if (sync_pattern_select == `AMC_SYNC_LSB)
						bus_o[b].data[0] <= act[b] & stb_q[b];
					else
						bus_o[b].data[0] <= act[b] & data_q[b][0];
					bus_o[b].strobe <= stb_act[b] & stb_q[b];
					bus_o[b].dclk <= dclk_act[b] & dclk_q[b];
				end
			end
		end
	endgenerate

	// Checks on the controller
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_instant;
		evt && m.lvds_en;
	endsequence

	sequence s_group_end;
		s_instant ##0 (m.align && last);
	endsequence

	// Word on bus A with its clock enabled on both launch edges
	sequence s_word_launch;
		upd[0] && dclk_act[0] ##1 dclk_act[0];
	endsequence

	a_dual_rate: assert property (!m.intlv && fall |-> !evt)
		else $error("falling edge sampled in two-channel mode");
	a_intlv_rate: assert property (m.lvds_en && m.intlv && fall |-> evt)
		else $error("falling edge missed in interleaved mode");
	a_swap_route: assert property (!m.intlv ##1 1 |-> chan_a_src_o == $past(m.swap))
		else $error("input swap not routed");
	a_dither_ctl: assert property (##1 1 |-> dither_on_o == $past(dith.on)
		&& dither_boost_o == $past(dith.boost))
		else $error("dither control not followed");
	a_round_ctl: assert property (##1 1 |-> dither_rounding_choice_o == $past(dith.round))
		else $error("rounding choice not followed");
	a_isel_trim: assert property (m.intlv ##1 1 |-> trim_sel_o == $past(m.isel)
		&& chan_b_src_o == $past(m.isel))
		else $error("interleaved input or trim wrong");
	a_swing_mode: assert property (swing == `AMC_SWING_HIZ |=> swing_highz_o && !swing_low_o)
		else $error("high impedance swing not driven");
	a_demux_off: assert property (!m.demux [*2] |-> bus_o[2] == '0 && bus_o[3] == '0)
		else $error("spare buses active without demux");
	a_strobe_gate: assert property (m.demux && !clock_strobe_enable_reg[0] |=> !bus_o[0].strobe)
		else $error("disabled strobe still driven");
	a_clock_gate: assert property (m.demux && !clock_strobe_enable_reg[4] |=> !bus_o[0].dclk)
		else $error("disabled clock still driven");
	a_lsb_strobe: assert property (sync_pattern_select == `AMC_SYNC_LSB
		|=> bus_o[0].strobe == 1'b0 && bus_o[1].strobe == 1'b0)
		else $error("dedicated strobe on in LSB mode");
	a_stagger: assert property (!m.align && m.intlv && upd != 4'h0 |-> $onehot(upd))
		else $error("staggered buses switched together");
	a_aligned: assert property (s_group_end |-> upd == act)
		else $error("aligned buses not switched together");
	a_strobe_sync: assert property (m.lvds_en && $past(m.lvds_en) && $changed(stb_q[0])
		|-> $changed(dclk_q[0]))
		else $error("strobe moved without its bus clock");

	// Bus geometry; a wrong count here misleads the receiver set-up
	a_dual_pair: assert property (!m.intlv && !m.demux |-> upd[0] == upd[1])
		else $error("two-channel buses updated apart");
	a_demux_split: assert property (!m.intlv && m.demux && !m.align |-> !(upd[0] && upd[2]))
		else $error("demux buses switched on one instant");
	a_two_bus: assert property (m.lvds_en && !m.demux
		&& sync_pattern_select != `AMC_SYNC_LSB
		|-> n_dclk == 3'h2 && n_stb == 3'h2 && n_pairs == `AMC_PAIRS_TWO)
		else $error("two-bus geometry wrong");
	a_four_bus: assert property (m.lvds_en && m.demux
		&& clock_strobe_enable_reg == 8'hff && sync_pattern_select != `AMC_SYNC_LSB
		|-> n_dclk == 3'h4 && n_stb == 3'h4 && n_pairs == `AMC_PAIRS_FOUR)
		else $error("four-bus geometry wrong");

	// Driver, trim and rate reporting
	a_swing_low: assert property (swing == `AMC_SWING_LOW |=> swing_low_o && !swing_highz_o)
		else $error("low swing not driven");
	a_trim_dual: assert property (!m.intlv |=> !trim_sel_o)
		else $error("trim follows input in two-channel mode");
	a_intlv_rates: assert property (m.intlv && !m.demux |-> rate_max == `AMC_RATE_INTLV2_MAX)
		else $error("interleaved two-bus rate limit wrong");
	a_dual_rates: assert property (!m.intlv && m.demux |-> rate_max == `AMC_RATE_DUAL4_MAX
		&& rate_min == `AMC_RATE_DUAL_MIN)
		else $error("two-channel four-bus rate limits wrong");

	// Word path on bus A, all four buses quiet when disabled; the receiver relies on strobe and clock moving with the word
	a_frame_mark: assert property (upd[0] |=> stb_q[0] == ($past(fc[0]) == `AMC_FRAME_LAST))
		else $error("frame strobe not on the last word");
	a_clock_launch: assert property (s_word_launch |=> bus_o[0].dclk != $past(bus_o[0].dclk))
		else $error("data clock did not toggle for a word");
	a_lsb_data: assert property (sync_pattern_select == `AMC_SYNC_LSB && act[0]
		|=> bus_o[0].data[0] == $past(stb_q[0]))
		else $error("strobe not carried in the data LSB");
	a_lvds_quiet: assert property (!m.lvds_en |=> bus_o == '0)
		else $error("bus active while outputs disabled");

endmodule // amc_mode_ctrl

// file: amc_regs.svh
// Register offsets, field positions, reset values and counts for the mode controller
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH
// Register byte offsets
`define AMC_ADDR_MODE 8'h00
`define AMC_ADDR_DITHER 8'h04
`define AMC_ADDR_SWING 8'h08
`define AMC_ADDR_CSE 8'h0c
`define AMC_ADDR_SYNC 8'h10
`define AMC_ADDR_STATUS 8'h14
`define AMC_ADDR_RATE 8'h18
// Mode register fields
`define AMC_MODE_INTLV 0
`define AMC_MODE_SWAP 1
`define AMC_MODE_ISEL 2
`define AMC_MODE_DEMUX 3
`define AMC_MODE_ALIGN 4
`define AMC_MODE_LVDS_EN 5
// Dither register fields
`define AMC_DITH_ON 0
`define AMC_DITH_BOOST 1
`define AMC_DITH_ROUND 2
// Reset values
`define AMC_MODE_RST 6'h00
`define AMC_DITH_RST 3'h1
`define AMC_SWING_RST 2'h0
`define AMC_CSE_RST 8'hff
`define AMC_SYNC_RST 2'h0
// Codes
`define AMC_SWING_LOW 2'h1
`define AMC_SWING_HIZ 2'h3
`define AMC_SYNC_LSB 2'h2
`define AMC_FRAME_LAST 3'h7
// Bus geometry
`define AMC_PAIRS_TWO 6'h18
`define AMC_PAIRS_FOUR 6'h30
// Sample rate limits in MSPS
`define AMC_RATE_INTLV_MIN 16'h03e8
`define AMC_RATE_INTLV2_MAX 16'h09c4
`define AMC_RATE_INTLV4_MAX 16'h1388
`define AMC_RATE_DUAL_MIN 16'h01f4
`define AMC_RATE_DUAL2_MAX 16'h05dc
`define AMC_RATE_DUAL4_MAX 16'h09c4
`endif

// file: amc_pkg.sv
// Types shared by the mode controller and its users
package amc_pkg;
	typedef struct packed {
		logic lvds_en;
		logic align;
		logic demux;
		logic isel;
		logic swap;
		logic intlv;
	} amc_mode_type;
	typedef struct packed {
		logic round;
		logic boost;
		logic on;
	} amc_dither_type;
	typedef struct packed {
		logic [11:0] data;
		logic strobe;
		logic dclk;
	} amc_lane_type;
endpackage

// file: amc_rx_model.sv
// Receiver model that captures each output bus on its own DDR data clock
module amc_rx_model (
	// Clock and clear
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Buses from the device
	input wire amc_pkg::amc_lane_type [3:0] bus_i,
	// Capture results per bus
	output logic [7:0] words_o [4],
	output logic [7:0] strobes_o [4],
	output logic [11:0] last_o [4]
);
	logic [3:0] dclk_q;

	// Capture on each clock edge only; a strobe off its clock edge is missed
	always_ff @(posedge core_clk_i)
	begin
		for (int i = 0; i < 4; i++)
		begin
			dclk_q[i] <= bus_i[i].dclk;
			if (rst_i)
			begin
				words_o[i] <= 8'h00;
				strobes_o[i] <= 8'h00;
				last_o[i] <= 12'h000;
			end
			else if (bus_i[i].dclk != dclk_q[i])
			begin
				words_o[i] <= words_o[i] + 8'h01;
				last_o[i] <= bus_i[i].data;
				strobes_o[i] <= strobes_o[i] + {7'h00, bus_i[i].strobe};
			end
		end
	end
endmodule // amc_rx_model

// file: amc_mode_ctrl_bench.sv
// Self-checking bench for the output mode controller
`include "amc_regs.svh"
module amc_mode_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, sample_clk_i, rx_clr;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, i;
	logic [11:0] conv_a_i, conv_b_i;
	logic interleave_o, chan_a_src_o, chan_b_src_o, trim_sel_o, swing_low_o, swing_highz_o;
	logic dither_on_o, dither_boost_o, dither_rounding_choice_o;
	amc_pkg::amc_lane_type [3:0] bus_o;
	logic [7:0] words [4];
	logic [7:0] strobes [4];
	logic [11:0] last [4];
	logic [3:0] sdiv;
	logic [5:0] md [5] = '{6'h20, 6'h30, 6'h28, 6'h21, 6'h39};
	logic [31:0] st [5] = '{32'h0018_0222, 32'h0018_0222, 32'h0030_0444, 32'h0018_0222,
		32'h0030_0444};
	logic [31:0] rt [5] = '{32'h05dc_01f4, 32'h05dc_01f4, 32'h09c4_01f4, 32'h09c4_03e8,
		32'h1388_03e8};
	int n_errors = 0;
	int n_checks = 0;

	amc_mode_ctrl i_amc_mode_ctrl (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .sample_clk_i, .conv_a_i, .conv_b_i, .interleave_o,
		.chan_a_src_o, .chan_b_src_o, .trim_sel_o, .dither_on_o, .dither_boost_o,
		.dither_rounding_choice_o, .swing_low_o, .swing_highz_o, .bus_o);
	amc_rx_model i_amc_rx_model (.core_clk_i, .rst_i(rx_clr), .bus_i(bus_o), .words_o(words),
		.strobes_o(strobes), .last_o(last));

	// System clock
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// Sampling clock of 160 ns, derived so it never moves on a sampling edge
	always @(posedge core_clk_i)
	begin
		sdiv <= sdiv + 4'h1;
		sample_clk_i <= sdiv[3];
	end

	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk(reg_rdata_o, exp);
	endtask

	// Outputs off, receiver cleared, then the new mode enabled
	task automatic restart(input logic [5:0] m);
		wr(`AMC_ADDR_MODE, {26'h0, m & 6'h1f});
		repeat (3) @(posedge core_clk_i);
		rx_clr <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		rx_clr <= 1'b0;
		wr(`AMC_ADDR_MODE, {26'h0, m});
	endtask

	task automatic wait_words(input int b, input int n);
		int k;
		for (k = 0; k < 3000 && words[b] < n; k++)
			@(posedge core_clk_i);
		if (k == 3000)
		begin
			n_errors++;
			end_of_test;
		end
		#1;
	endtask

	// Main sequence
	initial
	begin
		rst_i = 1'b1;
		rx_clr = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		sdiv = 4'h0;
		sample_clk_i = 1'b0;
		conv_a_i = 12'h123;
		conv_b_i = 12'h456;
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rx_clr <= 1'b0;
		#1 chk({30'h0, dither_on_o, chan_b_src_o}, 32'h3);
		rd(`AMC_ADDR_DITHER, 32'h1);
		rd(`AMC_ADDR_SWING, 32'h0);
		rd(`AMC_ADDR_CSE, 32'hff);
		rd(`AMC_ADDR_SYNC, 32'h0);
		rd(`AMC_ADDR_MODE, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			wr(`AMC_ADDR_DITHER, i);
			idle(3);
			chk({29'h0, dither_rounding_choice_o, dither_boost_o, dither_on_o}, i);
		end
		for (i = 0; i < 4; i++)
		begin
			wr(`AMC_ADDR_SWING, i);
			idle(3);
			chk({30'h0, swing_highz_o, swing_low_o}, {30'h0, i == 3, i == 1});
		end
		wr(`AMC_ADDR_MODE, 32'h02);
		idle(3);
		chk({28'h0, chan_a_src_o, chan_b_src_o, interleave_o, trim_sel_o}, 32'h8);
		wr(`AMC_ADDR_MODE, 32'h05);
		idle(3);
		chk({30'h0, interleave_o, trim_sel_o}, 32'h3);
		wr(`AMC_ADDR_MODE, 32'h01);
		idle(3);
		chk({30'h0, interleave_o, trim_sel_o}, 32'h2);
		wr(`AMC_ADDR_RATE, 32'h0);
		for (i = 0; i < 5; i++)
		begin
			restart(md[i]);
			rd(`AMC_ADDR_STATUS, st[i]);
			rd(`AMC_ADDR_RATE, rt[i]);
		end
		wr(`AMC_ADDR_CSE, 32'h71);
		rd(`AMC_ADDR_STATUS, 32'h0030_0314);
		wr(`AMC_ADDR_SYNC, 32'h2);
		rd(`AMC_ADDR_STATUS, 32'h0030_0304);
		wr(`AMC_ADDR_SYNC, 32'h0);
		restart(6'h20);
		rd(`AMC_ADDR_STATUS, 32'h0018_0222);
		// Dual channel, one bus per channel
		wr(`AMC_ADDR_CSE, 32'hff);
		restart(6'h20);
		wait_words(0, 16);
		chk({20'h0, last[0]}, 32'h123);
		chk({20'h0, last[1]}, 32'h456);
		chk({24'h0, strobes[0]}, 32'h2);
		chk({24'h0, words[2]}, 32'h0);
		// Strobe carried in the data LSB instead of its own pin
		wr(`AMC_ADDR_SYNC, 32'h2);
		restart(6'h20);
		wait_words(1, 8);
		chk({20'h0, last[1]}, 32'h457);
		chk({24'h0, strobes[1]}, 32'h0);
		wait_words(1, 9);
		chk({20'h0, last[1]}, 32'h456);
		wr(`AMC_ADDR_SYNC, 32'h0);
		// Demux by two with one clock and one strobe switched off
		wr(`AMC_ADDR_CSE, 32'hed);
		restart(6'h28);
		wait_words(3, 9);
		chk({24'h0, words[0]}, 32'h0);
		chk({24'h0, strobes[1]}, 32'h0);
		chk({31'h0, strobes[2] != 8'h00}, 32'h1);
		chk({20'h0, last[2]}, 32'h123);
		chk({20'h0, last[3]}, 32'h456);
		// Interleaved, two buses staggered: words alternate between A and B
		restart(6'h21);
		wait_words(1, 4);
		chk({24'h0, words[0]}, 32'h4);
		chk({20'h0, last[0] ^ last[1]}, 32'h575);
		// Interleaved, four buses aligned
		wr(`AMC_ADDR_CSE, 32'hff);
		restart(6'h39);
		wait_words(3, 4);
		chk({24'h0, words[0]}, 32'h4);
		wr(`AMC_ADDR_MODE, 32'h0);
		idle(3);
		chk({31'h0, |bus_o}, 32'h0);
		end_of_test;
	end
endmodule // amc_mode_ctrl_bench
